// >>> logic/i2s_port_pkg.sv
/*
 * Shared constants for the dual serial audio port.
 * Assumes a 200 MHz system clock; link pins are sampled synchronously.
 */
package i2s_port_pkg;
	localparam int WORD_BITS = 16;
	localparam int PORT_COUNT = 2;
	localparam int FRAME_SHORT = 32;
	localparam int FRAME_LONG = 50;
	localparam int HALF_SHORT = FRAME_SHORT / 2;
	localparam int HALF_LONG = FRAME_LONG / 2;
	// Fractional divider: phase accumulator steps by N, wraps at M
	localparam int ACC_BITS = 16;
	localparam logic [ACC_BITS-1:0] DIV_N_SHORT = 16'h00F0;
	localparam logic [ACC_BITS-1:0] DIV_N_LONG = 16'h0177;
	localparam logic [ACC_BITS-1:0] DIV_M = 16'h3D09;
	localparam logic [5:0] HALF_SHORT_CNT = 6'h10;
	localparam logic [5:0] HALF_LONG_CNT = 6'h19;
	localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;
endpackage

// >>> logic/i2s_audio_port.sv
/*
 * Two independent I2S audio ports, master or slave each.
 * Each port carries a 16-bit left and right word per frame, MSB first.
 * Master mode rates come from the divider constants of the package.
 * Assumes external link pins are synchronous to clk_sys_i (already
 * conditioned) and that slave bit clock stays below 3.072 MHz.
 * The parallel side supplies transmit words when tx_load_o pulses and
 * takes received words when rx_valid_o pulses.
 * Pin output enables are high while the port drives the pin.
 */
`timescale 1ns/1ps
// How it works
// - Two ports exist and each runs on its own mode, clock and data.
// - Master drives clock and select, slave takes both; data always out.
// - Words are 16 bits with the left word MSB at the bus MSB position.
// - The MSB goes out on the falling edge one bit after a select change.
// - Word select low marks left, high marks right, both directions.
// - Output bits change on falling edges and are captured on rising edges.
// - Master frames at 48 kHz with 32 or 50 bit clocks per frame.
// - Master bit clock comes from an N over M divider of the reference.
// - Slave takes any bit clock rate, at most 3.072 MHz from outside.
module i2s_audio_port
	import i2s_port_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [PORT_COUNT-1:0] master_i,
	input wire logic [PORT_COUNT-1:0] long_frame_i,
	input wire logic [PORT_COUNT-1:0] sck_i,
	output logic [PORT_COUNT-1:0] sck_o,
	output logic [PORT_COUNT-1:0] sck_oe_o,
	input wire logic [PORT_COUNT-1:0] ws_i,
	output logic [PORT_COUNT-1:0] ws_o,
	output logic [PORT_COUNT-1:0] ws_oe_o,
	output logic [PORT_COUNT-1:0] sdo_o,
	input wire logic [PORT_COUNT-1:0] sdi_i,
	input wire logic [PORT_COUNT*WORD_BITS-1:0] tx_left_i,
	input wire logic [PORT_COUNT*WORD_BITS-1:0] tx_right_i,
	output logic [PORT_COUNT-1:0] tx_load_o,
	output logic [PORT_COUNT*WORD_BITS-1:0] rx_left_o,
	output logic [PORT_COUNT*WORD_BITS-1:0] rx_right_o,
	output logic [PORT_COUNT-1:0] rx_valid_o
);

	// ------------------------------------------------------------
	// Serial shift helper
	// ------------------------------------------------------------
	function automatic logic [WORD_BITS-1:0] shift_in(
		input logic [WORD_BITS-1:0] word,
		input logic bit_in
	);
		shift_in = {word[WORD_BITS-2:0], bit_in};
	endfunction

	genvar g;
	generate
	for (g = 0; g < PORT_COUNT; g++) begin : gen_port
		// ------------------------------------------------------------
		// Master clock generation
		// ------------------------------------------------------------
		logic [ACC_BITS-1:0] acc_q, acc_d, step;
		logic [ACC_BITS:0] acc_sum;
		logic tick;
		logic msck_q, mws_q;
		logic [5:0] mcnt_q;
		logic [5:0] half_len;
		logic ws_turn;

		assign step = long_frame_i[g] ? DIV_N_LONG : DIV_N_SHORT;
		assign half_len = long_frame_i[g] ? HALF_LONG_CNT : HALF_SHORT_CNT;
		// Word select turns once per half-frame
		assign ws_turn = mcnt_q == half_len - 6'h01;
		// Tick at twice the bit rate: each tick toggles the clock
		assign acc_sum = {1'b0, acc_q} + {1'b0, step};
		assign tick = acc_sum >= {1'b0, DIV_M};
		assign acc_d = tick ? acc_sum[ACC_BITS-1:0] - DIV_M
			: acc_sum[ACC_BITS-1:0];

		// Divider and word counter sit idle in slave mode
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				acc_q <= 16'h0000;
				msck_q <= 1'b0;
				mws_q <= 1'b0;
				mcnt_q <= 6'h00;
			end else if (!master_i[g]) begin
				acc_q <= 16'h0000;
				msck_q <= 1'b0;
				mws_q <= 1'b0;
				mcnt_q <= 6'h00;
			end else begin
				acc_q <= acc_d;
				if (tick) begin
					msck_q <= ~msck_q;
					// Word select moves on the falling edge
					if (msck_q) begin
						if (ws_turn) begin
							mcnt_q <= 6'h00;
							mws_q <= ~mws_q;
						end else begin
							mcnt_q <= mcnt_q + 6'h01;
						end
					end
				end
			end
		end

		// ------------------------------------------------------------
		// Pin direction and edge detection
		// ------------------------------------------------------------
		logic sck, ws, sck_prev_q, ws_prev_q;
		logic rise, fall;

		assign sck = master_i[g] ? msck_q : sck_i[g];
		assign ws = master_i[g] ? mws_q : ws_i[g];
		assign sck_o[g] = msck_q;
		assign ws_o[g] = mws_q;
		// Output enables follow the mode
		assign sck_oe_o[g] = master_i[g];
		assign ws_oe_o[g] = master_i[g];
		// Edges are seen one system clock late
		assign rise = sck & ~sck_prev_q;
		assign fall = ~sck & sck_prev_q;

		// ------------------------------------------------------------
		// Transmit shifter
		// ------------------------------------------------------------
		logic [WORD_BITS-1:0] tx_sh_q, rx_sh_q;
		logic [WORD_BITS-1:0] rxl_q, rxr_q;
		logic [4:0] tx_cnt_q, rx_cnt_q;
		logic sdo_q, load_q, rxv_q, ws_fall_q, rx_ws_q;
		logic ws_edge, launch, rx_take, rx_last;
		logic [WORD_BITS-1:0] tx_word, rx_word;

		assign ws_edge = ws != ws_prev_q;
		// The fall after a select change launches the next word
		assign launch = fall & ws_fall_q;
		// Select as seen at that change: low selects left
		assign tx_word = ws_prev_q ? tx_right_i[g*WORD_BITS +: WORD_BITS]
			: tx_left_i[g*WORD_BITS +: WORD_BITS];

		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				sck_prev_q <= 1'b0;
				ws_prev_q <= 1'b0;
				ws_fall_q <= 1'b0;
				tx_sh_q <= WORD_RST;
				tx_cnt_q <= 5'h10;
				sdo_q <= 1'b0;
				load_q <= 1'b0;
			end else begin
				sck_prev_q <= sck;
				load_q <= 1'b0;
				if (fall) begin
					ws_prev_q <= ws;
					ws_fall_q <= ws_edge;
					if (launch) begin
						tx_sh_q <= shift_in(tx_word, 1'b0);
						sdo_q <= tx_word[WORD_BITS-1];
						tx_cnt_q <= 5'h01;
						load_q <= 1'b1;
					end else if (tx_cnt_q < 5'h10) begin
						sdo_q <= tx_sh_q[WORD_BITS-1];
						tx_sh_q <= shift_in(tx_sh_q, 1'b0);
						tx_cnt_q <= tx_cnt_q + 5'h01;
					end else begin
						sdo_q <= 1'b0;
					end
				end
			end
		end

		// ------------------------------------------------------------
		// Receive shifter
		// ------------------------------------------------------------
		// Only the first sixteen rises of a word are taken
		assign rx_take = rise & (rx_cnt_q < 5'h10);
		assign rx_last = rx_take & (rx_cnt_q == 5'h0F);
		assign rx_word = shift_in(rx_sh_q, sdi_i[g]);

		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				rx_sh_q <= WORD_RST;
				rx_cnt_q <= 5'h10;
				rx_ws_q <= 1'b0;
				rxl_q <= WORD_RST;
				rxr_q <= WORD_RST;
				rxv_q <= 1'b0;
			end else begin
				rxv_q <= rx_last;
				if (rx_take) begin
					rx_sh_q <= rx_word;
					rx_cnt_q <= rx_cnt_q + 5'h01;
				end
				if (rx_last && rx_ws_q) begin
					rxr_q <= rx_word;
				end
				if (rx_last && !rx_ws_q) begin
					rxl_q <= rx_word;
				end
				// New word: count from zero, tag with its select
				if (launch) begin
					rx_cnt_q <= 5'h00;
					rx_ws_q <= ws_prev_q;
				end
			end
		end

		// ------------------------------------------------------------
		// Outputs
		// ------------------------------------------------------------
		assign sdo_o[g] = sdo_q;
		assign tx_load_o[g] = load_q;
		assign rx_valid_o[g] = rxv_q;
		assign rx_left_o[g*WORD_BITS +: WORD_BITS] = rxl_q;
		assign rx_right_o[g*WORD_BITS +: WORD_BITS] = rxr_q;
	end
	endgenerate

endmodule

// >>> verification/i2s_codec_model.sv
/* Far-side codec for a slave port; needs a free-running system clock. */
`timescale 1ns/1ps
module i2s_codec_model #(
	parameter int HALF = 33
) (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic sdo_i,
	input wire logic [15:0] left_i,
	input wire logic [15:0] right_i,
	output logic sck_o = 1'b1,
	output logic ws_o = 1'b1,
	output logic sdi_o = 1'b0,
	output logic [15:0] cap_l_o,
	output logic [15:0] cap_r_o
);
// Bit period 2*HALF cycles stays under the slave limit
always begin
	@(posedge clk_i);
	#1 sdi_o = ~sdi_o;
	while (run_i) for (int k = 0; k < 32; k++) begin
		sck_o = 1'b0;
		ws_o = k >= 15 && k < 31;
		sdi_o = k < 16 ? left_i[15 - k] : right_i[31 - k];
		repeat (HALF) @(posedge clk_i);
		#1 sck_o = 1'b1;
		if (k < 16) cap_l_o[15 - k] = sdo_i;
		else cap_r_o[31 - k] = sdo_i;
		repeat (HALF) @(posedge clk_i);
		#1;
	end
end
endmodule

// >>> verification/i2s_audio_port_checker.sv
/* Port timing checks; bound to the audio port top. */
`timescale 1ns/1ps
module i2s_audio_port_checker
	import i2s_port_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [PORT_COUNT-1:0] master_i,
	input wire logic [PORT_COUNT-1:0] sck_i,
	input wire logic [PORT_COUNT-1:0] sck_o,
	input wire logic [PORT_COUNT-1:0] sck_oe_o,
	input wire logic [PORT_COUNT-1:0] ws_o,
	input wire logic [PORT_COUNT-1:0] sdo_o,
	input wire logic [PORT_COUNT-1:0] tx_load_o,
	input wire logic [PORT_COUNT-1:0] rx_valid_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!rst_n_i);
sequence s_edge;
	master_i[0] && $changed(sck_o[0]);
endsequence
a_oe_follows_mode: assert property (sck_oe_o == master_i)
	else $error("clock enable wrong");
a_clock_holds: assert property (s_edge |=> $stable(sck_o[0])[*8])
	else $error("clock too fast");
a_clock_runs: assert property (s_edge |-> ##[1:180] $changed(sck_o[0]))
	else $error("clock stalled");
a_ws_on_fall: assert property ($changed(ws_o[0]) |-> !sck_o[0])
	else $error("ws off fall");
a_sdo_master: assert property ($changed(sdo_o[0]) |-> !sck_o[0])
	else $error("sdo off fall");
a_sdo_slave: assert property (!master_i[1] && $changed(sdo_o[1]) |-> !sck_i[1])
	else $error("slave sdo off fall");
a_load_pulse: assert property (tx_load_o[1] |-> !sck_i[1] ##1 !tx_load_o[1])
	else $error("load pulse wrong");
a_valid_pulse: assert property (rx_valid_o[1] |-> sck_i[1] ##1 !rx_valid_o[1])
	else $error("valid pulse wrong");
endmodule
bind i2s_audio_port i2s_audio_port_checker u_chk (.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i), .master_i(master_i), .sck_i(sck_i), .sck_o(sck_o),
	.sck_oe_o(sck_oe_o), .ws_o(ws_o), .sdo_o(sdo_o), .tx_load_o(tx_load_o),
	.rx_valid_o(rx_valid_o));

// >>> verification/i2s_audio_port_tb.sv
/* Port 0 master looped back, port 1 slave to the codec model. */
`timescale 1ns/1ps
module i2s_audio_port_tb;
logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, sck_m, ws_m, sdi_m;
logic [1:0] long_fr = 2'h1;
logic [1:0] sck_o, sck_oe_o, ws_o, ws_oe_o, sdo_o, tx_load_o, rx_valid_o;
logic [31:0] tx_l = 32'h0000A5C3, tx_r = 32'h00003C5A, rx_l, rx_r;
logic [15:0] cap_l, cap_r;
logic [31:0] rows [3] = '{32'h80017FFE, 32'hFFFF0000, 32'h1234ABCD};
int fails = 0, samples_checked = 0, cyc = 0;
always #2.5 clk = ~clk;
i2s_audio_port uut (.clk_sys_i(clk), .rst_n_i(rst_n), .master_i(2'h1),
	.long_frame_i(long_fr), .sck_i({sck_m, 1'b0}), .sck_o(sck_o),
	.sck_oe_o(sck_oe_o), .ws_i({ws_m, 1'b0}), .ws_o(ws_o), .ws_oe_o(ws_oe_o),
	.sdo_o(sdo_o), .sdi_i({sdi_m, sdo_o[0]}), .tx_left_i(tx_l),
	.tx_right_i(tx_r), .tx_load_o(tx_load_o), .rx_left_o(rx_l),
	.rx_right_o(rx_r), .rx_valid_o(rx_valid_o));
i2s_codec_model #(.HALF(33)) peer (.clk_i(clk), .run_i(run),
	.sdo_i(sdo_o[1]), .left_i(~tx_l[31:16]), .right_i(~tx_r[31:16]),
	.sck_o(sck_m), .ws_o(ws_m), .sdi_o(sdi_m), .cap_l_o(cap_l),
	.cap_r_o(cap_r));
task chk(input string n, input logic [15:0] e, input logic [15:0] s);
	samples_checked++;
	if (s !== e) begin
		fails++;
		$display("[FAIL] %s exp %h got %h", n, e, s);
	end
endtask
task stop_test;
	$display("checks %0d fails %0d", samples_checked, fails);
	if (fails == 0 && samples_checked > 0) $display("bench passed");
	else $display("bench failed");
	$finish;
endtask
always @(posedge clk) begin
	cyc++;
	if (cyc == 60000) begin
		fails++;
		stop_test();
	end
end
initial begin
	repeat (10) @(posedge clk);
	#1 rst_n = 1'b1;
	run = 1'b1;
	foreach (rows[i]) begin
		tx_l[31:16] = rows[i][31:16];
		tx_r[31:16] = rows[i][15:0];
		repeat (6400) @(posedge clk);
		#1 chk("codec l", rows[i][31:16], cap_l);
		chk("codec r", rows[i][15:0], cap_r);
		chk("rx l", ~rows[i][31:16], rx_l[31:16]);
		chk("rx r", ~rows[i][15:0], rx_r[31:16]);
	end
	repeat (14000) @(posedge clk);
	#1 chk("loop l", 16'hA5C3, rx_l[15:0]);
	chk("loop r", 16'h3C5A, rx_r[15:0]);
	rst_n = 1'b0;
	run = 1'b0;
	long_fr = 2'h0;
	tx_l[15:0] = 16'h5AA5;
	tx_r[15:0] = 16'hC33C;
	repeat (2) @(posedge clk);
	#1 chk("rst", 16'h0000, {6'h00, sdo_o, tx_load_o, rx_valid_o, sck_o, ws_o});
	chk("oe", 16'h0005, {12'h000, ws_oe_o, sck_oe_o});
	rst_n = 1'b1;
	repeat (14000) @(posedge clk);
	#1 chk("short l", 16'h5AA5, rx_l[15:0]);
	chk("short r", 16'hC33C, rx_r[15:0]);
	stop_test();
end
endmodule
